/* File: bench/pcis_monitor.sv */
`timescale 1ns/1ps
module pcis_monitor #(
  parameter int unsigned INRUSH_CYCLES = 50,
  parameter int unsigned CLASS_CYCLES  = pcis_pkg::CLASS_CYC,
  parameter int unsigned MARK_CYCLES   = pcis_pkg::MARK_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        class_drive,
  input  wire logic        mark_drive,
  input  wire logic        port_output_pin,
  input  wire logic        redetect_req,
  input  wire logic        inrush_limiting
);
  logic [23:0] cls_n_r;
  logic [23:0] mrk_n_r;
  logic [23:0] lim_n_r;

  // Pulse lengths run to hundreds of thousands of cycles, so they are counted.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cls_n_r <= '0;
      mrk_n_r <= '0;
      lim_n_r <= '0;
    end else begin
      cls_n_r <= class_drive ? cls_n_r + 24'h1 : '0;
      mrk_n_r <= mark_drive ? mrk_n_r + 24'h1 : '0;
      lim_n_r <= (port_output_pin && inrush_limiting) ? lim_n_r + 24'h1 : '0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence mark_end;
    $fell(mark_drive);
  endsequence
  sequence reclass;
    ##[0:4] class_drive;
  endsequence

  drive_excl_a: assert property (
    !(class_drive && mark_drive)) else $error("class and mark overlap");
  power_quiet_a: assert property (
    port_output_pin |-> !class_drive && !mark_drive)
    else $error("probe voltage while powered");
  class_len_a: assert property (
    $fell(class_drive) |-> cls_n_r == CLASS_CYCLES)
    else $error("class pulse length wrong");
  mark_len_a: assert property (
    $fell(mark_drive) |-> mrk_n_r == MARK_CYCLES)
    else $error("mark pause length wrong");
  mark_reclass_a: assert property (
    mark_end |-> reclass) else $error("no second class pulse");
  inrush_cut_a: assert property (
    lim_n_r <= INRUSH_CYCLES + 8) else $error("inrush not cut off");
  redet_off_a: assert property (
    redetect_req |-> !port_output_pin ##1 !redetect_req)
    else $error("redetect while powered");
  ready_pulse_a: assert property (
    pready |-> psel && penable ##1 !pready) else $error("bad ready");
  err_zero_a: assert property (
    pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
endmodule

/* File: bench/pcis_pd_model.sv */
`timescale 1ns/1ps
module pcis_pd_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        class_drive,
  input  wire logic        mark_drive,
  input  wire logic        port_output_pin,
  input  wire logic [2:0]  cls_a,
  input  wire logic [2:0]  cls_b,
  input  wire logic [15:0] inrush_len,
  output logic      [2:0]  class_meas,
  output logic             inrush_limiting
);
  logic        marked_r;
  logic        cd_q_r;
  logic [15:0] on_n_r;

  // The pulse after a mark answers its own code, so bad pairs can be posed.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      marked_r <= 1'b0;
      cd_q_r   <= 1'b0;
      on_n_r   <= '0;
    end else begin
      cd_q_r <= class_drive;
      on_n_r <= port_output_pin ? on_n_r + 16'h1 : '0;
      if (mark_drive) begin
        marked_r <= 1'b1;
      end else if (cd_q_r && !class_drive) begin
        marked_r <= 1'b0;
      end
    end
  end

  // Without class voltage the device draws no class current.
  assign class_meas = class_drive ? (marked_r ? cls_b : cls_a) : 3'h0;
  assign inrush_limiting = port_output_pin && (on_n_r < inrush_len);
endmodule

/* File: bench/pcis_seq_tb.sv */
`timescale 1ns/1ps
module pcis_seq_tb;
  localparam int unsigned INR = 50;
  localparam int unsigned CLS = 600;
  localparam int unsigned MRK = 500;
  logic        ref_clk, reset, standalone_pin, detect_done, detect_good;
  logic        inrush_limiting, psel, penable, pwrite, pready, pslverr;
  logic        class_drive, mark_drive, port_output_pin, redetect_req, er;
  logic [2:0]  class_meas, cls_a, cls_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  overload_threshold;
  logic [7:0]  current_limit_threshold;
  logic [15:0] inrush_len;
  int          n_errors, num_checks;

  pcis_seq #(.INRUSH_CYCLES(INR), .CLASS_CYCLES(CLS), .MARK_CYCLES(MRK))
    u_dut (.ref_clk, .reset, .standalone_pin,
    .detect_done, .detect_good, .class_meas, .inrush_limiting, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .class_drive, .mark_drive, .port_output_pin, .redetect_req,
    .overload_threshold, .current_limit_threshold);
  pcis_pd_model u_pd (.ref_clk, .reset, .class_drive, .mark_drive,
    .port_output_pin, .cls_a, .cls_b, .inrush_len, .class_meas,
    .inrush_limiting);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] m, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return class_drive;
      1: return redetect_req;
      default: return port_output_pin;
    endcase
  endfunction

  // Long class and mark pulses need generous bounds; the short waits use 20 cycles.
  task automatic wt(input int k, input logic v, input int lim, input string nm);
    int i;
    i = 0;
    while (sig(k) !== v && i < lim) begin
      @(posedge ref_clk);
      i++;
    end
    chk(nm, {31'h0, v}, {31'h0, sig(k)});
  endtask

  task automatic det(input logic g);
    @(posedge ref_clk);
    detect_done <= 1'b1;
    detect_good <= g;
    @(posedge ref_clk);
    detect_done <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic rst(input logic sp);
    standalone_pin <= sp;
    reset <= 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20_000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end

  initial begin
    {reset, detect_done, detect_good, psel, penable, pwrite} = 6'h00;
    {paddr, pwdata, n_errors, num_checks} = '0;
    {standalone_pin, cls_a, cls_b, inrush_len} = {1'b1, 22'h00_0000};
    rst(1'b1);
    rdc(pcis_pkg::A_CTRL, pcis_pkg::CTRL_RST, 32'hffff_ffff, "ctrl");
    rdc(pcis_pkg::A_THRESH, {16'h0, pcis_pkg::LIM_T1, 1'b0,
        pcis_pkg::OVL_C3}, 32'hffff_ffff, "thresh");
    apb(1'b0, 12'h01c, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    $display("test reset done");
    apb(1'b1, pcis_pkg::A_CTRL, 32'h0000_0004);
    det(1'b1);
    repeat (30) @(posedge ref_clk);
    chk("shut", 32'h0, {31'h0, class_drive});
    apb(1'b1, pcis_pkg::A_CTRL, 32'h0000_0005);
    cls_a <= pcis_pkg::CLS_1;
    det(1'b1);
    repeat (30) @(posedge ref_clk);
    chk("manual idle", 32'h0, {31'h0, class_drive});
    apb(1'b1, pcis_pkg::A_CMD, 32'h0000_0001);
    wt(0, 1'b1, 20, "class start");
    wt(0, 1'b0, CLS + 20, "class end");
    rdc(pcis_pkg::A_STATUS, {29'h0, pcis_pkg::CLS_1}, 32'h7, "cls");
    inrush_len <= 16'hffff;
    apb(1'b1, pcis_pkg::A_CMD, 32'h0000_0002);
    wt(2, 1'b1, 20, "pwr on");
    wt(2, 1'b0, INR + 20, "pwr cut");
    rdc(pcis_pkg::A_FAULT, 32'h1, 32'h1, "fault");
    apb(1'b1, pcis_pkg::A_FAULT, 32'h0000_0001);
    rdc(pcis_pkg::A_FAULT, 32'h0, 32'h1, "fault clr");
    $display("test manual done");
    apb(1'b1, pcis_pkg::A_HPMODE, 32'h0000_0001);
    apb(1'b1, pcis_pkg::A_CTRL, 32'h0000_0006);
    det(1'b0);
    apb(1'b1, pcis_pkg::A_CMD, 32'h0000_0002);
    repeat (10) @(posedge ref_clk);
    chk("no power", 32'h0, {31'h0, port_output_pin});
    rdc(pcis_pkg::A_FAULT, 32'h1, 32'h1, "hp fault");
    apb(1'b1, pcis_pkg::A_FAULT, 32'h0000_0001);
    cls_a <= pcis_pkg::CLS_4;
    cls_b <= pcis_pkg::CLS_2;
    apb(1'b1, pcis_pkg::A_CTRL, 32'h0000_0007);
    det(1'b1);
    wt(0, 1'b1, 20, "auto class");
    wt(1, 1'b1, 2 * CLS + MRK + 50, "redetect");
    chk("withheld", 32'h0, {31'h0, port_output_pin});
    rdc(pcis_pkg::A_HPSTAT, 32'h1, 32'h1, "second ran");
    rdc(pcis_pkg::A_STATUS, {29'h0, pcis_pkg::CLS_2}, 32'h7, "last");
    apb(1'b1, pcis_pkg::A_HPSTAT, 32'h0000_0001);
    $display("test two event done");
    apb(1'b1, pcis_pkg::A_THRESH, 32'h0000_0000);
    cls_a <= 3'h0;
    inrush_len <= 16'h000a;
    det(1'b1);
    wt(2, 1'b1, CLS + 50, "auto power");
    repeat (INR + 20) @(posedge ref_clk);
    chk("inrush ok", 32'h1, {31'h0, port_output_pin});
    rdc(pcis_pkg::A_STATUS, {29'h0, pcis_pkg::CLS_0}, 32'h7, "none");
    rdc(pcis_pkg::A_HPSTAT, 32'h0, 32'h1, "one pulse");
    rdc(pcis_pkg::A_THRESH, {16'h0, pcis_pkg::LIM_T1, 1'b0,
        pcis_pkg::OVL_C3}, 32'hffff_ffff, "c0 thresh");
    apb(1'b1, pcis_pkg::A_THRESH, 32'h0000_c05c);
    rdc(pcis_pkg::A_THRESH, 32'h0000_c05c, 32'hffff_ffff, "rewrite");
    chk("still on", 32'h1, {31'h0, port_output_pin});
    apb(1'b1, pcis_pkg::A_CMD, 32'h0000_0004);
    wt(2, 1'b0, 20, "pwr off");
    $display("test auto done");
    rst(1'b0);
    apb(1'b1, pcis_pkg::A_CTRL, 32'h0000_0007);
    det(1'b1);
    repeat (30) @(posedge ref_clk);
    chk("strap low", 32'h0, {31'h0, class_drive});
    $display("test strap done");
    summarize();
  end
endmodule

bind pcis_seq pcis_monitor #(.INRUSH_CYCLES(INRUSH_CYCLES),
  .CLASS_CYCLES(CLASS_CYCLES), .MARK_CYCLES(MARK_CYCLES)) u_mon (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .class_drive(class_drive), .mark_drive(mark_drive),
  .port_output_pin(port_output_pin), .redetect_req(redetect_req),
  .inrush_limiting(inrush_limiting));

/* File: pkg/pcis_pkg.sv */
// Behaviour
// R01: Semi-auto or standalone mode with class enabled classifies right after good detection.
// R02: Manual mode classifies only on host command when class is enabled.
// R03: Classification holds class voltage for 12 ms, then samples port current.
// R04: Finished classification writes the found class into the port status field.
// R05: Standalone mode derives overload and current-limit thresholds from class.
// R06: Classification is inhibited by standalone strap low, shutdown, or class enable clear.
// R07: No signature reports Class 0 and is handled as Class 3.
// R08: Two-event enabled and Class 4 drives mark voltage, pauses, reclassifies.
// R09: Running the second cycle sets the high-power indication bit.
// R10: Host enables two-event classification by setting the high-power mode bit.
// R11: First result Class 0 to 3 skips the second cycle, treated as lower power.
// R12: Standalone powers any class except Class 4 then 0 to 3; then redetects.
// R13: Class field always holds the most recent classification pulse result.
// R14: Host rewrites of thresholds are accepted while the port stays powered.
// R15: Accepted turn-on starts the inrush timer, running while current is limited.
// R16: Inrush timer expiry turns the port off and flags an inrush-timeout fault.
// R17: Semi-auto high-power turn-on needs good detection, else inrush-timeout fault.
// R18: Standalone repeats detection and classification until found, then powers.
// R19: Class is held as an encoded field, updated atomically per pulse.
package pcis_pkg;
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned CLASS_MS     = 12;
  localparam int unsigned MARK_MS      = 10;
  localparam int unsigned INRUSH_MS    = 60;
  localparam int unsigned CLASS_CYC    = CLK_HZ / 1000 * CLASS_MS;
  localparam int unsigned MARK_CYC     = CLK_HZ / 1000 * MARK_MS;
  localparam int unsigned INRUSH_CYC   = CLK_HZ / 1000 * INRUSH_MS;
  localparam int unsigned CNT_W        = 24;

  localparam logic [11:0] A_CTRL       = 12'h000;
  localparam logic [11:0] A_STATUS     = 12'h004;
  localparam logic [11:0] A_HPMODE     = 12'h008;
  localparam logic [11:0] A_HPSTAT     = 12'h00c;
  localparam logic [11:0] A_THRESH     = 12'h010;
  localparam logic [11:0] A_FAULT      = 12'h014;
  localparam logic [11:0] A_CMD        = 12'h018;

  // Control fields.
  localparam int unsigned C_MODE_LO    = 0;
  localparam int unsigned C_CLS_EN     = 2;
  localparam logic [1:0]  MODE_SHUT    = 2'h0;
  localparam logic [1:0]  MODE_MANUAL  = 2'h1;
  localparam logic [1:0]  MODE_SEMI    = 2'h2;
  localparam logic [1:0]  MODE_AUTO    = 2'h3;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0004;
  // Command bits, write one to act.
  localparam int unsigned K_CLASS      = 0;
  localparam int unsigned K_PWR_ON     = 1;
  localparam int unsigned K_PWR_OFF    = 2;

  // Encoded class values.
  localparam logic [2:0]  CLS_NONE     = 3'h0;
  localparam logic [2:0]  CLS_0        = 3'h1;
  localparam logic [2:0]  CLS_1        = 3'h2;
  localparam logic [2:0]  CLS_2        = 3'h3;
  localparam logic [2:0]  CLS_3        = 3'h4;
  localparam logic [2:0]  CLS_4        = 3'h5;

  // Threshold codes, arbitrary plain defaults.
  localparam logic [6:0]  OVL_C1       = 7'h10;
  localparam logic [6:0]  OVL_C2       = 7'h1e;
  localparam logic [6:0]  OVL_C3       = 7'h36;
  localparam logic [6:0]  OVL_C4       = 7'h5c;
  localparam logic [7:0]  LIM_T1       = 8'h80;
  localparam logic [7:0]  LIM_T2       = 8'hc0;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b000_0001,
    ST_CLASS  = 7'b000_0010,
    ST_MARK   = 7'b000_0100,
    ST_DECIDE = 7'b000_1000,
    ST_INRUSH = 7'b001_0000,
    ST_ON     = 7'b010_0000,
    ST_REDET  = 7'b100_0000
  } pcis_state_t;
endpackage

/* File: pkg/pcis_tmr_if.sv */
`timescale 1ns/1ps
interface pcis_tmr_if;
  logic                 load;
  logic [23:0]          count;
  logic                 done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

/* File: rtl/pcis_seq.sv */
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module pcis_seq #(
  parameter int unsigned INRUSH_CYCLES = pcis_pkg::INRUSH_CYC,
  parameter int unsigned CLASS_CYCLES  = pcis_pkg::CLASS_CYC,
  parameter int unsigned MARK_CYCLES   = pcis_pkg::MARK_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        standalone_pin,
  input  wire logic        detect_done,
  input  wire logic        detect_good,
  input  wire logic [2:0]  class_meas,
  input  wire logic        inrush_limiting,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             class_drive,
  output logic             mark_drive,
  output logic             port_output_pin,
  output logic             redetect_req,
  output logic [6:0]       overload_threshold,
  output logic [7:0]       current_limit_threshold
);
  pcis_tmr_if tif();
  pcis_timer u_tmr (
    .ref_clk (ref_clk),
    .reset   (reset),
    .t       (tif)
  );

  logic [1:0]  sa_s_r;
  logic        sa_strap_r;
  logic [1:0]  rst_cnt_r;
  logic [1:0]  inr_wait_r;
  logic [1:0]  dd_s_r;
  logic [1:0]  dg_s_r;
  logic [1:0]  il_s_r;
  logic [5:0]  cm_s_r;
  logic [31:0] ctrl_r;
  logic        hp_en_r;
  logic        hp_stat_r;
  logic [2:0]  class_r;
  logic        fault_r;
  logic        det_good_r;
  logic        second_r;
  pcis_pkg::pcis_state_t st_r;
  pcis_pkg::pcis_state_t st_nxt;
  logic        wr_acc;
  logic        rd_acc;
  logic [1:0]  mode;
  logic        cls_ok;
  logic        cmd_cls;
  logic        cmd_on;
  logic        cmd_off;
  logic        det_evt;
  logic [2:0]  cls_in;

  // Pin-level inputs are synchronised before use.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sa_s_r <= 2'h0;
      dd_s_r <= 2'h0;
      dg_s_r <= 2'h0;
      il_s_r <= 2'h0;
      cm_s_r <= 6'h00;
    end else begin
      sa_s_r <= {sa_s_r[0], standalone_pin};
      dd_s_r <= {dd_s_r[0], detect_done};
      dg_s_r <= {dg_s_r[0], detect_good};
      il_s_r <= {il_s_r[0], inrush_limiting};
      cm_s_r <= {cm_s_r[2:0], class_meas};
    end
  end

  // The strap is caught once after reset release; later changes are ignored.
  // The synchroniser is cleared by reset, so the catch waits until it holds
  // the pin level, on the third edge after release.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rst_cnt_r  <= 2'h0;
      sa_strap_r <= 1'b0;
    end else if (rst_cnt_r != 2'h3) begin
      rst_cnt_r <= rst_cnt_r + 2'h1;
      if (rst_cnt_r == 2'h2) begin
        sa_strap_r <= sa_s_r[1];
      end
    end
  end

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign mode    = ctrl_r[pcis_pkg::C_MODE_LO +: 2];
  assign cls_ok  = sa_strap_r && (mode != pcis_pkg::MODE_SHUT) &&
                   ctrl_r[pcis_pkg::C_CLS_EN]; // R06
  assign cmd_cls = wr_acc && (paddr == pcis_pkg::A_CMD) &&
                   pwdata[pcis_pkg::K_CLASS];
  assign cmd_on  = wr_acc && (paddr == pcis_pkg::A_CMD) &&
                   pwdata[pcis_pkg::K_PWR_ON];
  assign cmd_off = wr_acc && (paddr == pcis_pkg::A_CMD) &&
                   pwdata[pcis_pkg::K_PWR_OFF];
  assign det_evt = dd_s_r[1];
  // Absent signature reads as Class 0.
  assign cls_in  = (cm_s_r[5:3] == pcis_pkg::CLS_NONE) ?
                   pcis_pkg::CLS_0 : cm_s_r[5:3]; // R07

  function automatic logic [6:0] ovl_of(input logic [2:0] c);
    unique case (c)
      pcis_pkg::CLS_1: ovl_of = pcis_pkg::OVL_C1;
      pcis_pkg::CLS_2: ovl_of = pcis_pkg::OVL_C2;
      pcis_pkg::CLS_4: ovl_of = pcis_pkg::OVL_C4;
      default:         ovl_of = pcis_pkg::OVL_C3; // R07
    endcase
  endfunction

  // Write decode shared by the HPSTAT, FAULT and THRESH registers; CTRL and HPMODE decode their writes inline.
  function automatic logic wr_hit(input logic [11:0] a);
    return wr_acc && (paddr == a);
  endfunction

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      det_good_r <= 1'b0;
    end else if (det_evt) begin
      det_good_r <= dg_s_r[1];
    end
  end

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      pcis_pkg::ST_IDLE: begin
        if (det_evt && dg_s_r[1] && cls_ok &&
            (mode == pcis_pkg::MODE_SEMI || mode == pcis_pkg::MODE_AUTO)) begin
          st_nxt = pcis_pkg::ST_CLASS; // R01
        end else if (cmd_cls && cls_ok && mode == pcis_pkg::MODE_MANUAL) begin
          st_nxt = pcis_pkg::ST_CLASS; // R02
        end else if (det_evt && dg_s_r[1] && mode == pcis_pkg::MODE_AUTO) begin
          st_nxt = pcis_pkg::ST_INRUSH; // R18
        end else if (det_evt && mode == pcis_pkg::MODE_AUTO) begin
          st_nxt = pcis_pkg::ST_REDET; // R18
        end else if (cmd_on && mode != pcis_pkg::MODE_SHUT &&
                     !(mode == pcis_pkg::MODE_SEMI && hp_en_r &&
                       !det_good_r)) begin
          st_nxt = pcis_pkg::ST_INRUSH; // R17
        end
      end
      pcis_pkg::ST_CLASS: begin
        if (tif.done) begin
          st_nxt = pcis_pkg::ST_DECIDE; // R03
        end
      end
      pcis_pkg::ST_MARK: begin
        if (tif.done) begin
          st_nxt = pcis_pkg::ST_CLASS; // R08
        end
      end
      pcis_pkg::ST_DECIDE: begin
        if (!second_r && hp_en_r && class_r == pcis_pkg::CLS_4) begin
          st_nxt = pcis_pkg::ST_MARK; // R08
        end else if (mode != pcis_pkg::MODE_AUTO) begin
          st_nxt = pcis_pkg::ST_IDLE; // R11
        end else if (second_r && class_r != pcis_pkg::CLS_4) begin
          st_nxt = pcis_pkg::ST_REDET; // R12
        end else begin
          st_nxt = pcis_pkg::ST_INRUSH; // R12
        end
      end
      pcis_pkg::ST_INRUSH: begin
        if (cmd_off || tif.done) begin
          st_nxt = pcis_pkg::ST_IDLE; // R16
        end else if (!il_s_r[1] && inr_wait_r == 2'h3) begin
          st_nxt = pcis_pkg::ST_ON; // R15
        end
      end
      pcis_pkg::ST_ON: begin
        if (cmd_off || mode == pcis_pkg::MODE_SHUT) begin
          st_nxt = pcis_pkg::ST_IDLE;
        end
      end
      pcis_pkg::ST_REDET: begin
        st_nxt = pcis_pkg::ST_IDLE;
      end
      default: st_nxt = pcis_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= pcis_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The limit flag reaches the state machine three edges after power rises,
  // so it is ignored until then; a port that never limits leaves after that.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      inr_wait_r <= 2'h0;
    end else if (st_r != pcis_pkg::ST_INRUSH) begin
      inr_wait_r <= 2'h0;
    end else if (inr_wait_r != 2'h3) begin
      inr_wait_r <= inr_wait_r + 2'h1; // R15
    end
  end

  // Phase lengths are cut to the timer width on purpose; all defaults fit.
  localparam logic [23:0] CNT_CLASS = 24'(CLASS_CYCLES);
  localparam logic [23:0] CNT_MARK  = 24'(MARK_CYCLES);
  localparam logic [23:0] CNT_INR   = 24'(INRUSH_CYCLES);

  // Each timed phase loads the shared timer on entry.
  always_comb begin
    tif.load  = 1'b0;
    tif.count = 24'h00_0000;
    if (st_nxt == pcis_pkg::ST_CLASS && st_r != pcis_pkg::ST_CLASS) begin
      tif.load  = 1'b1;
      tif.count = CNT_CLASS; // R03
    end else if (st_nxt == pcis_pkg::ST_MARK && st_r != pcis_pkg::ST_MARK) begin
      tif.load  = 1'b1;
      tif.count = CNT_MARK;
    end else if (st_nxt == pcis_pkg::ST_INRUSH &&
                 st_r != pcis_pkg::ST_INRUSH) begin
      tif.load  = 1'b1;
      tif.count = CNT_INR; // R15
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      class_r   <= pcis_pkg::CLS_NONE;
      second_r  <= 1'b0;
      hp_stat_r <= 1'b0;
    end else begin
      if (st_r == pcis_pkg::ST_CLASS && tif.done) begin
        class_r <= cls_in; // R04 R13 R19
      end
      if (st_r == pcis_pkg::ST_MARK && tif.done) begin
        second_r  <= 1'b1;
        hp_stat_r <= 1'b1; // R09
      end else if (st_r == pcis_pkg::ST_IDLE && st_nxt ==
                   pcis_pkg::ST_CLASS) begin
        second_r <= 1'b0;
        if (wr_hit(pcis_pkg::A_HPSTAT) && pwdata[0]) begin
          hp_stat_r <= 1'b0;
        end
      end else if (wr_hit(pcis_pkg::A_HPSTAT) && pwdata[0]) begin
        hp_stat_r <= 1'b0;
      end
    end
  end

  // Inrush timeout fault; hardware set wins over a software clear.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_r <= 1'b0;
    end else if ((st_r == pcis_pkg::ST_INRUSH && tif.done && !cmd_off) ||
                 (st_r == pcis_pkg::ST_IDLE && cmd_on &&
                  mode == pcis_pkg::MODE_SEMI && hp_en_r &&
                  !det_good_r)) begin
      fault_r <= 1'b1; // R16 R17
    end else if (wr_hit(pcis_pkg::A_FAULT) && pwdata[0]) begin
      fault_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r  <= pcis_pkg::CTRL_RST;
      hp_en_r <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == pcis_pkg::A_CTRL) begin
        ctrl_r <= {29'h0000_0000, pwdata[2:0]};
      end
      if (paddr == pcis_pkg::A_HPMODE) begin
        hp_en_r <= pwdata[0]; // R10
      end
    end
  end

  // Thresholds: automatic from class in standalone, host writable at any time.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      overload_threshold      <= pcis_pkg::OVL_C3;
      current_limit_threshold <= pcis_pkg::LIM_T1;
    end else if (wr_hit(pcis_pkg::A_THRESH)) begin
      overload_threshold      <= pwdata[6:0]; // R14
      current_limit_threshold <= pwdata[15:8]; // R14
    end else if (st_r == pcis_pkg::ST_DECIDE && st_nxt ==
                 pcis_pkg::ST_INRUSH) begin
      overload_threshold      <= ovl_of(class_r); // R05
      current_limit_threshold <= (class_r == pcis_pkg::CLS_4) ?
                                 pcis_pkg::LIM_T2 : pcis_pkg::LIM_T1; // R05
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      class_drive     <= 1'b0;
      mark_drive      <= 1'b0;
      port_output_pin <= 1'b0;
      redetect_req    <= 1'b0;
    end else begin
      class_drive     <= (st_nxt == pcis_pkg::ST_CLASS); // R03
      mark_drive      <= (st_nxt == pcis_pkg::ST_MARK); // R08
      port_output_pin <= (st_nxt == pcis_pkg::ST_INRUSH) ||
                         (st_nxt == pcis_pkg::ST_ON); // R16
      redetect_req    <= (st_nxt == pcis_pkg::ST_REDET); // R12
    end
  end

  // Zero-wait APB slave; unmapped addresses read zero with an error.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          pcis_pkg::A_CTRL:   prdata <= ctrl_r;
          pcis_pkg::A_STATUS: prdata <= {26'h000_0000, st_r == pcis_pkg::ST_ON,
                                         det_good_r, 1'b0, class_r};
          pcis_pkg::A_HPMODE: prdata <= {31'h0000_0000, hp_en_r};
          pcis_pkg::A_HPSTAT: prdata <= {31'h0000_0000, hp_stat_r};
          pcis_pkg::A_THRESH: prdata <= {16'h0000, current_limit_threshold,
                                         1'b0, overload_threshold};
          pcis_pkg::A_FAULT:  prdata <= {31'h0000_0000, fault_r};
          pcis_pkg::A_CMD:    prdata <= 32'h0000_0000;
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

/* File: rtl/pcis_timer.sv */
`timescale 1ns/1ps
module pcis_timer (
  input  wire logic     ref_clk,
  input  wire logic     reset,
  pcis_tmr_if.tmr       t
);
  logic [23:0] cnt_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 24'h00_0000;
    end else if (t.load) begin
      cnt_r <= t.count;
    end else if (cnt_r != 24'h00_0000) begin
      cnt_r <= cnt_r - 24'h00_0001;
    end
  end
  // Done pulses for one cycle, while the count sits at one in the last cycle of the phase.
  assign t.done = (cnt_r == 24'h00_0001);
endmodule
